// file: logic/cli_pkg.sv
package cli_pkg;
   // link format modes
   localparam logic [4:0] CLI_FMT_FOUR_SINGLE_CHANNEL = 5'h04;
   localparam logic [4:0] CLI_FMT_FIVE_SINGLE_INPUT = 5'h05;
   localparam logic [4:0] CLI_FMT_SIX_DUAL_CHANNEL = 5'h06;
   localparam logic [4:0] CLI_FMT_SEVEN_DUAL_INPUT = 5'h07;
   localparam int CLI_LANES = 4;
   localparam int CLI_SAMPLE_W = 8;
   // reset values
   localparam logic [4:0] CLI_FMT_RESET = 5'h04;
   localparam logic [4:0] CLI_KM1_RESET = 5'h1f;
   // link alignment timing: ILA length in multiframes, calibration run length in clock cycles
   localparam logic [3:0] CLI_ILA_MULTIFRAMES = 4'h4;
   localparam logic [5:0] CLI_CAL_CYCLES = 6'h20;
   // frames carried per lane beat
   localparam logic [1:0] CLI_FRAMES_PER_BEAT = 2'h1;

   typedef enum {CLI_LINK_OFF, CLI_LINK_CGS, CLI_LINK_ILA, CLI_LINK_DATA} cli_link_state_type;

   typedef struct packed {
      logic [4:0] fmt;
      logic [4:0] km1;
      logic sync_from_timestamp;
      logic cal_background;
      logic cal_offset;
      logic overrange_enable;
   } cli_cfg_type;

   typedef struct packed {
      logic [CLI_SAMPLE_W-1:0] rise;
      logic [CLI_SAMPLE_W-1:0] fall;
   } cli_pair_type;
endpackage

// file: logic/cli_cfg_store.sv
`timescale 1ns/1ns
`default_nettype none
// shadow of the configuration, captured only while both machines are halted
module cli_cfg_store
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // update
   input wire logic halted_i,
   input wire cli_pkg::cli_cfg_type cfg_i,
   // held copy
   output cli_pkg::cli_cfg_type cfg_o
);
   import cli_pkg::*;

   cli_cfg_type cfg_q;

   assign cfg_o = cfg_q;

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         cfg_q <= '{fmt: CLI_FMT_RESET, km1: CLI_KM1_RESET, default: 1'b0};
      end
      else if (halted_i)
      begin
         cfg_q <= cfg_i;
      end
   end
endmodule
`default_nettype wire

// file: logic/cli_converter_link.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - enabled link machine advances according to receiver SYNC
// - single-channel mode samples on both clock edges
// - mode 4 single-channel on 4 lanes, mode 6 dual-channel on 4 lanes
// - mode 5 single-input, mode 7 dual-input at full converter rate
module cli_converter_link
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // control bits
   input wire logic SERIAL_LINK_ENABLE_I,
   input wire logic CALIBRATION_ENABLE_I,
   input wire logic CALIBRATION_SOFT_TRIGGER_I,
   input wire logic [4:0] LINK_FORMAT_MODE_I,
   input wire logic [4:0] MULTIFRAME_LENGTH_MINUS_ONE_I,
   input wire logic SYNC_SOURCE_TIMESTAMP_I,
   input wire logic CAL_BACKGROUND_I,
   input wire logic CAL_OFFSET_I,
   input wire logic OVERRANGE_ENABLE_I,
   // sync from receiver, active low
   input wire logic SINGLE_ENDED_SYNC_N_I,
   input wire logic TIMESTAMP_SYNC_N_I,
   // samples: rise and fall of channel A, rise of channel B
   input wire logic [7:0] SAMPLE_A_RISE_I,
   input wire logic [7:0] SAMPLE_A_FALL_I,
   input wire logic [7:0] SAMPLE_B_I,
   input wire logic [7:0] OVERRANGE_LEVEL_I,
   // lane outputs
   output logic [31:0] LANE_DATA_O,
   output logic LANE_K_O,
   // status
   output logic [1:0] LINK_STATE_O,
   output logic LINK_UP_O,
   output logic CAL_BUSY_O,
   output logic CAL_DONE_O,
   output logic OVERRANGE_O,
   output logic DUAL_EDGE_O,
   output logic FORMAT_VALID_O
);
   import cli_pkg::*;

   cli_cfg_type cfg_in;
   cli_cfg_type cfg;
   cli_link_state_type link_q, link_d;
   logic trig_q;
   logic [5:0] cal_cnt_q;
   logic cal_busy_q, cal_done_q;
   logic [4:0] frame_q;
   logic [3:0] mf_q;
   logic [31:0] lane_q;
   logic k_q, ovr_q;
   logic up_q, dual_q, valid_q, overrange_enable_q;
   cli_cfg_type cfg_next;

   wire halted = !SERIAL_LINK_ENABLE_I && !CALIBRATION_ENABLE_I;
   wire sync_n = cfg.sync_from_timestamp ? TIMESTAMP_SYNC_N_I : SINGLE_ENDED_SYNC_N_I;
   wire mf_end = (frame_q == cfg.km1);
   wire fmt_single = (cfg.fmt == CLI_FMT_FOUR_SINGLE_CHANNEL) ||
                     (cfg.fmt == CLI_FMT_FIVE_SINGLE_INPUT);
   wire fmt_dual = (cfg.fmt == CLI_FMT_SIX_DUAL_CHANNEL) ||
                   (cfg.fmt == CLI_FMT_SEVEN_DUAL_INPUT);
   // flags decode what the shadow takes at this edge, so they keep its timing
   wire next_single = (cfg_next.fmt == CLI_FMT_FOUR_SINGLE_CHANNEL) ||
                      (cfg_next.fmt == CLI_FMT_FIVE_SINGLE_INPUT);
   wire next_dual = (cfg_next.fmt == CLI_FMT_SIX_DUAL_CHANNEL) ||
                    (cfg_next.fmt == CLI_FMT_SEVEN_DUAL_INPUT);
   wire trig_rise = CALIBRATION_SOFT_TRIGGER_I && !trig_q;
   wire cal_start = CALIBRATION_ENABLE_I && trig_rise && !cal_busy_q;
   // single-channel interleaves both edges of channel A into each lane word
   wire [31:0] single_word = {SAMPLE_A_FALL_I, SAMPLE_A_RISE_I,
                              SAMPLE_A_FALL_I, SAMPLE_A_RISE_I};
   wire [31:0] dual_word = {SAMPLE_B_I, SAMPLE_A_RISE_I, SAMPLE_B_I, SAMPLE_A_RISE_I};
   wire [31:0] data_word = fmt_single ? single_word : dual_word;
   wire ovr_hit = overrange_enable_q &&
                  ((SAMPLE_A_RISE_I >= OVERRANGE_LEVEL_I) ||
                   (fmt_single ? (SAMPLE_A_FALL_I >= OVERRANGE_LEVEL_I)
                               : (SAMPLE_B_I >= OVERRANGE_LEVEL_I)));

   assign cfg_in = '{fmt: LINK_FORMAT_MODE_I, km1: MULTIFRAME_LENGTH_MINUS_ONE_I,
                     sync_from_timestamp: SYNC_SOURCE_TIMESTAMP_I,
                     cal_background: CAL_BACKGROUND_I, cal_offset: CAL_OFFSET_I,
                     overrange_enable: OVERRANGE_ENABLE_I};
   assign cfg_next = halted ? cfg_in : cfg;

   cli_cfg_store u_store
   (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .halted_i(halted),
      .cfg_i(cfg_in),
      .cfg_o(cfg)
   );

   // link machine follows receiver sync
   always_comb
   begin
      link_d = link_q;
      case (link_q)
         CLI_LINK_OFF:
         begin
            if (SERIAL_LINK_ENABLE_I && (fmt_single || fmt_dual))
            begin
               link_d = CLI_LINK_CGS;
            end
         end
         CLI_LINK_CGS:
         begin
            if (sync_n && mf_end)
            begin
               link_d = CLI_LINK_ILA;
            end
         end
         CLI_LINK_ILA:
         begin
            if (!sync_n)
            begin
               link_d = CLI_LINK_CGS;
            end
            else if (mf_end && (mf_q == CLI_ILA_MULTIFRAMES - 4'h1))
            begin
               link_d = CLI_LINK_DATA;
            end
         end
         CLI_LINK_DATA:
         begin
            if (!sync_n)
            begin
               link_d = CLI_LINK_CGS;
            end
         end
         default:
         begin
            link_d = CLI_LINK_OFF;
         end
      endcase
      if (!SERIAL_LINK_ENABLE_I)
      begin
         link_d = CLI_LINK_OFF;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         link_q <= CLI_LINK_OFF;
      end
      else
      begin
         link_q <= link_d;
      end
   end

   // frame and multiframe counters; restart when link is not running
   always_ff @(posedge CLK_I)
   begin
      if (RST_I || (link_q == CLI_LINK_OFF))
      begin
         frame_q <= 5'h00;
         mf_q <= 4'h0;
      end
      else if (link_d != link_q)
      begin
         frame_q <= 5'h00;
         mf_q <= 4'h0;
      end
      else if (mf_end)
      begin
         frame_q <= 5'h00;
         mf_q <= mf_q + 4'h1;
      end
      else
      begin
         frame_q <= frame_q + 5'h01;
      end
   end

   // calibration: fixed-length run launched by soft trigger edge
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         trig_q <= 1'b0;
         cal_cnt_q <= 6'h00;
         cal_busy_q <= 1'b0;
         cal_done_q <= 1'b0;
      end
      else
      begin
         trig_q <= CALIBRATION_SOFT_TRIGGER_I;
         if (!CALIBRATION_ENABLE_I)
         begin
            cal_busy_q <= 1'b0; // disabling aborts a run in progress
            cal_cnt_q <= 6'h00;
         end
         else if (cal_start)
         begin
            cal_busy_q <= 1'b1;
            cal_done_q <= 1'b0;
            cal_cnt_q <= CLI_CAL_CYCLES - 6'h01;
         end
         else if (cal_busy_q)
         begin
            if (cal_cnt_q == 6'h00)
            begin
               cal_busy_q <= 1'b0;
               cal_done_q <= 1'b1;
            end
            else
            begin
               cal_cnt_q <= cal_cnt_q - 6'h01;
            end
         end
      end
   end

   // lane word: K characters in CGS, frame and multiframe counts in ILA, samples in data phase, zero when off
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         lane_q <= 32'h00000000;
         k_q <= 1'b0;
         ovr_q <= 1'b0;
      end
      else
      begin
         k_q <= (link_q == CLI_LINK_CGS);
         ovr_q <= ovr_hit;
         case (link_q)
            CLI_LINK_CGS: lane_q <= 32'hbcbcbcbc;
            CLI_LINK_ILA: lane_q <= {3'h0, frame_q, 4'h0, mf_q, 16'h0000};
            CLI_LINK_DATA: lane_q <= data_word;
            default: lane_q <= 32'h00000000;
         endcase
      end
   end

   // overrange enable is written after calibration restarts, so only the link must be halted
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         up_q <= 1'b0;
         dual_q <= (CLI_FMT_RESET >= CLI_FMT_FOUR_SINGLE_CHANNEL) &&
                   (CLI_FMT_RESET <= CLI_FMT_FIVE_SINGLE_INPUT);
         valid_q <= (CLI_FMT_RESET >= CLI_FMT_FOUR_SINGLE_CHANNEL) &&
                    (CLI_FMT_RESET <= CLI_FMT_SEVEN_DUAL_INPUT);
         overrange_enable_q <= 1'b0;
      end
      else
      begin
         up_q <= (link_d == CLI_LINK_DATA);
         dual_q <= next_single;
         valid_q <= next_single || next_dual;
         if (!SERIAL_LINK_ENABLE_I)
         begin
            overrange_enable_q <= OVERRANGE_ENABLE_I;
         end
      end
   end

   assign LANE_DATA_O = lane_q;
   assign LANE_K_O = k_q;
   assign LINK_STATE_O = link_q[1:0];
   assign LINK_UP_O = up_q;
   assign CAL_BUSY_O = cal_busy_q;
   assign CAL_DONE_O = cal_done_q;
   assign OVERRANGE_O = ovr_q;
   assign DUAL_EDGE_O = dual_q;
   assign FORMAT_VALID_O = valid_q;
endmodule
`default_nettype wire

// file: test/cli_converter_link_chk.sv
`timescale 1ns/1ns
`default_nettype none
module cli_converter_link_chk
(
   // controls
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic SERIAL_LINK_ENABLE_I,
   input wire logic CALIBRATION_ENABLE_I,
   input wire logic CALIBRATION_SOFT_TRIGGER_I,
   input wire logic [4:0] LINK_FORMAT_MODE_I,
   input wire logic SINGLE_ENDED_SYNC_N_I,
   input wire logic TIMESTAMP_SYNC_N_I,
   // results
   input wire logic [31:0] LANE_DATA_O,
   input wire logic LANE_K_O,
   input wire logic [1:0] LINK_STATE_O,
   input wire logic CAL_BUSY_O,
   input wire logic CAL_DONE_O,
   input wire logic DUAL_EDGE_O,
   input wire logic FORMAT_VALID_O
);
   logic [6:0] busy_cnt_q;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   always_ff @(posedge CLK_I)
      busy_cnt_q <= (RST_I || !CAL_BUSY_O) ? 7'h00 : busy_cnt_q + 7'h01;
   a_off_leave: assert property (
      LINK_STATE_O == 2'h0 && SERIAL_LINK_ENABLE_I && FORMAT_VALID_O |=> LINK_STATE_O == 2'h1)
      else $error("link stayed off");
   a_bad_fmt: assert property (
      LINK_STATE_O == 2'h0 && !FORMAT_VALID_O |=> LINK_STATE_O == 2'h0) else $error("bad fmt");
   a_cgs_word: assert property (
      LINK_STATE_O == 2'h1 |=> LANE_K_O && LANE_DATA_O == 32'hbcbcbcbc) else $error("cgs word");
   a_sync_drop: assert property (LINK_STATE_O[1] && SERIAL_LINK_ENABLE_I &&
      !SINGLE_ENDED_SYNC_N_I && !TIMESTAMP_SYNC_N_I |=> LINK_STATE_O == 2'h1) else $error("sync");
   a_dual_edge: assert property (!SERIAL_LINK_ENABLE_I && !CALIBRATION_ENABLE_I
      |=> DUAL_EDGE_O == ($past(LINK_FORMAT_MODE_I) inside {5'h04, 5'h05})) else $error("dual");
   a_fmt_valid: assert property (!SERIAL_LINK_ENABLE_I && !CALIBRATION_ENABLE_I
      |=> FORMAT_VALID_O == ($past(LINK_FORMAT_MODE_I) inside {[5'h04:5'h07]})) else $error("fmt");
   a_cal_launch: assert property ($rose(CALIBRATION_SOFT_TRIGGER_I) &&
      CALIBRATION_ENABLE_I && !CAL_BUSY_O |=> CAL_BUSY_O) else $error("cal launch");
   a_cal_len: assert property ($fell(CAL_BUSY_O) && CALIBRATION_ENABLE_I
      |-> busy_cnt_q == 7'h20 && CAL_DONE_O) else $error("cal length");
   c_data: cover property (LINK_STATE_O == 2'h3);
   c_resync: cover property (LINK_STATE_O == 2'h3 ##1 LINK_STATE_O == 2'h1);
   c_cal: cover property ($fell(CAL_BUSY_O) && CAL_DONE_O);
endmodule
bind cli_converter_link cli_converter_link_chk chk_u
(
   .CLK_I(CLK_I),
   .RST_I(RST_I),
   .SERIAL_LINK_ENABLE_I(SERIAL_LINK_ENABLE_I),
   .CALIBRATION_ENABLE_I(CALIBRATION_ENABLE_I),
   .CALIBRATION_SOFT_TRIGGER_I(CALIBRATION_SOFT_TRIGGER_I),
   .LINK_FORMAT_MODE_I(LINK_FORMAT_MODE_I),
   .SINGLE_ENDED_SYNC_N_I(SINGLE_ENDED_SYNC_N_I),
   .TIMESTAMP_SYNC_N_I(TIMESTAMP_SYNC_N_I),
   .LANE_DATA_O(LANE_DATA_O),
   .LANE_K_O(LANE_K_O),
   .LINK_STATE_O(LINK_STATE_O),
   .CAL_BUSY_O(CAL_BUSY_O),
   .CAL_DONE_O(CAL_DONE_O),
   .DUAL_EDGE_O(DUAL_EDGE_O),
   .FORMAT_VALID_O(FORMAT_VALID_O)
);
`default_nettype wire

// file: test/cli_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module cli_host_model
(
   // clock
   input wire logic clk_i,
   // writes to the device
   output var logic link_en_o,
   output var logic cal_en_o,
   output var logic trig_o,
   output var cli_pkg::cli_cfg_type cfg_o
);
   import cli_pkg::*;
   initial {link_en_o, cal_en_o, trig_o, cfg_o} = '0;
   task automatic setup(input logic [4:0] fmt, input logic [4:0] km1, input logic ts);
      @(posedge clk_i) link_en_o <= 1'b0;
      @(posedge clk_i) cal_en_o <= 1'b0;
      @(posedge clk_i) cfg_o <= '{fmt, km1, ts, 1'b1, 1'b1, 1'b0};
      @(posedge clk_i) cal_en_o <= 1'b1;
      @(posedge clk_i) cfg_o.overrange_enable <= 1'b1;
      @(posedge clk_i) link_en_o <= 1'b1;
   endtask
   task automatic fire;
      @(posedge clk_i) trig_o <= 1'b0;
      @(posedge clk_i) trig_o <= 1'b1;
   endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import cli_pkg::*;
   logic clk = 1'b0, rst = 1'b1, se_n = 1'b0, ts_n = 1'b0;
   logic [7:0] ar = 8'h00, af = 8'h00, b = 8'h00, lvl = 8'h00;
   logic le, ce, tg, k, up, busy, done, ovr, de, fv;
   logic [31:0] lane;
   logic [1:0] st;
   logic [4:0] m;
   cli_cfg_type cfg;
   int fail_count = 0, n_tests = 0, km, n;
   always #5 clk = ~clk;
   cli_host_model host_u (.clk_i(clk), .link_en_o(le), .cal_en_o(ce), .trig_o(tg), .cfg_o(cfg));
   cli_converter_link dut_u (.CLK_I(clk), .RST_I(rst), .SERIAL_LINK_ENABLE_I(le),
      .CALIBRATION_ENABLE_I(ce), .CALIBRATION_SOFT_TRIGGER_I(tg), .LINK_FORMAT_MODE_I(cfg.fmt),
      .MULTIFRAME_LENGTH_MINUS_ONE_I(cfg.km1), .SYNC_SOURCE_TIMESTAMP_I(cfg.sync_from_timestamp),
      .CAL_BACKGROUND_I(cfg.cal_background), .CAL_OFFSET_I(cfg.cal_offset),
      .OVERRANGE_ENABLE_I(cfg.overrange_enable), .SINGLE_ENDED_SYNC_N_I(se_n),
      .TIMESTAMP_SYNC_N_I(ts_n), .SAMPLE_A_RISE_I(ar), .SAMPLE_A_FALL_I(af), .SAMPLE_B_I(b),
      .OVERRANGE_LEVEL_I(lvl), .LANE_DATA_O(lane), .LANE_K_O(k), .LINK_STATE_O(st),
      .LINK_UP_O(up), .CAL_BUSY_O(busy), .CAL_DONE_O(done), .OVERRANGE_O(ovr),
      .DUAL_EDGE_O(de), .FORMAT_VALID_O(fv));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (fail_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wst(input logic [1:0] s);
      for (int i = 0; i < 200 && st !== s; i++)
         @(negedge clk);
      chk(32'(st), 32'(s));
   endtask
   initial
   begin
      repeat (6000) @(posedge clk);
      fail_count++;
      test_done;
   end
   initial
   begin
      void'($urandom(81));
      repeat (8) @(posedge clk);
      chk(32'(de), 32'h1);
      rst <= 1'b0;
      for (m = 5'h04; m <= 5'h08; m++)
      begin
         km = $urandom_range(7, 0);
         host_u.setup(m, km[4:0], m[0]);
         @(posedge clk);
         // only the unselected sync line asks for data
         se_n <= m[0];
         ts_n <= ~m[0];
         {ar, af, b, lvl} <= $urandom;
         wst(m == 5'h08 ? 2'h0 : 2'h1);
         repeat (40) @(negedge clk);
         chk(32'(st), m == 5'h08 ? 32'h0 : 32'h1);
         chk(32'(de), 32'(m < 5'h06));
         chk(32'(fv), 32'(m < 5'h08));
         chk(32'(ovr), 32'((ar >= lvl) || ((m < 5'h06 ? af : b) >= lvl)));
         if (m < 5'h08)
         begin
            chk({k, lane[30:0]}, 32'hbcbcbcbc);
            @(posedge clk);
            se_n <= ~m[0];
            ts_n <= m[0];
            wst(2'h2);
            for (n = 0; n < 300 && st === 2'h2; n++)
               @(negedge clk);
            chk(n, 32'(CLI_ILA_MULTIFRAMES) * (km + 1));
            chk(32'(st), 32'h3);
            @(negedge clk);
            chk(32'(up), 32'h1);
            chk(lane, m < 5'h06 ? {af, ar, af, ar} : {b, ar, b, ar});
            @(posedge clk);
            se_n <= 1'b0;
            ts_n <= 1'b0;
            wst(2'h1);
         end
      end
      host_u.fire();
      for (n = 0; n < 10 && busy !== 1'b1; n++)
         @(negedge clk);
      for (n = 0; n < 100 && busy === 1'b1; n++)
         @(negedge clk);
      chk(n, 32);
      chk(32'(done), 32'h1);
      test_done;
   end
endmodule
`default_nettype wire
